/* probe_mux_pkg.sv */
// constants and types shared by the banked signal probe multiplexer
package probe_mux_pkg;

	// ----------------------------------------------------------------
	// build-time defaults
	// ----------------------------------------------------------------
	localparam int PIN_COUNT_DEFAULT  = 8;
	localparam int BANK_COUNT_DEFAULT = 4;
	localparam int COUNT_MIN          = 1;
	localparam int COUNT_MAX          = 255;
	localparam int SRC_COUNT          = 4;
	localparam int SRC_WIDTH          = 2;
	localparam int SEL_WIDTH          = 8;
	localparam int LANE_WIDTH         = 3;
	localparam int ADDR_WIDTH         = 8;
	localparam int DATA_WIDTH         = 32;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_WIDTH-1:0] CTRL_OFFSET      = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] BANK_SEL_OFFSET  = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET    = 8'h08;
	localparam logic [ADDR_WIDTH-1:0] SAMPLES_OFFSET   = 8'h0C;
	localparam logic [ADDR_WIDTH-1:0] LANE_SEL_OFFSET  = 8'h10;
	localparam logic [ADDR_WIDTH-1:0] LANE_DATA_OFFSET = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_BIT      = 0;
	localparam int CTRL_SRC_LSB       = 8;
	localparam int STATUS_BANK_LSB    = 0;
	localparam int STATUS_DRIVE_BIT   = 8;
	localparam int STATUS_MODE_BIT    = 9;
	localparam int STATUS_BANKS_LSB   = 16;
	localparam int STATUS_PINS_LSB    = 24;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [SEL_WIDTH-1:0]  TRISTATE_CODE    = 8'hFF;
	localparam logic [SEL_WIDTH-1:0]  POWERUP_BANK_DEF = 8'h00;
	localparam logic [SRC_WIDTH-1:0]  SRC_SEL_RESET    = 2'h0;
	localparam logic [LANE_WIDTH-1:0] LANE_SEL_RESET   = 3'h0;
	localparam logic [DATA_WIDTH-1:0] WORD_ZERO        = 32'h0000_0000;
	localparam logic [DATA_WIDTH-1:0] COUNT_STEP       = 32'h0000_0001;

	typedef enum logic {
		OUTPUT_TIMING,
		OUTPUT_STATE
	} output_mode_type;

endpackage

/* banked_signal_probe_mux.sv */
// banked debug probe multiplexer with apb control registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// Overview of operation
// - pin count parameter from 1 to 255 gives that many probe pins
// - bank count 1 to 255; each bank gives one signal per pin
// - timing mode passes selected bank to pins with no device clock
// - state mode registers selected bank on chosen sample clock signal
// - sample clock selection acts only in registered state mode
// - reset puts pins tri-stated or one chosen bank driven
// - active bank can be changed at run time by the host
module banked_signal_probe_mux #(
	parameter int                    PIN_COUNT          = probe_mux_pkg::PIN_COUNT_DEFAULT,
	parameter int                    BANK_COUNT         = probe_mux_pkg::BANK_COUNT_DEFAULT,
	parameter bit                    POWERUP_TRISTATE   = 1'b1,
	parameter logic [7:0]            POWERUP_BANK       = probe_mux_pkg::POWERUP_BANK_DEF,
	parameter bit                    POWERUP_REGISTERED = 1'b0
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	input  wire logic [BANK_COUNT*PIN_COUNT-1:0] bank_signals,
	input  wire logic [3:0]                    sample_sources,
	output logic [PIN_COUNT-1:0]               probe_out,
	output logic [PIN_COUNT-1:0]               probe_oe_n
);

	// ----------------------------------------------------------------
	// derived constants
	// ----------------------------------------------------------------
	localparam logic [7:0] BANK_LIMIT  = 8'(BANK_COUNT);
	localparam logic [7:0] PIN_LIMIT   = 8'(PIN_COUNT);
	localparam int         LANE_WORDS  = (PIN_COUNT + 31) / 32;
	localparam logic [2:0] LANE_LAST   = 3'(LANE_WORDS - 1);
	localparam logic [7:0] SEL_RESET   = POWERUP_TRISTATE ?
		probe_mux_pkg::TRISTATE_CODE : POWERUP_BANK;
	localparam bit         DRIVE_RESET = !POWERUP_TRISTATE && (POWERUP_BANK < BANK_LIMIT);
	localparam probe_mux_pkg::output_mode_type MODE_RESET = POWERUP_REGISTERED ?
		probe_mux_pkg::OUTPUT_STATE : probe_mux_pkg::OUTPUT_TIMING;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	probe_mux_pkg::output_mode_type     mode;
	logic [1:0]                         sample_src_sel;
	logic [7:0]                         bank_sel;
	logic [2:0]                         lane_sel;
	logic [31:0]                        sample_count;
	logic                               src_prev;
	logic                               sample_level;
	logic                               sample_edge;
	logic                               bank_valid;
	logic [PIN_COUNT-1:0]               bank_mux;
	logic [PIN_COUNT-1:0]               probe_state;
	logic [PIN_COUNT-1:0]               probe_view;
	logic                               apb_access;
	logic                               apb_setup_done;
	logic                               wr_commit;
	logic                               addr_hit;
	logic [31:0]                        read_word;
	logic [31:0]                        lane_word;

	// ----------------------------------------------------------------
	// apb handshake
	// ----------------------------------------------------------------
	assign apb_access     = psel & penable;
	assign apb_setup_done = apb_access & ~pready;
	assign wr_commit      = apb_access & pready & pwrite;

	// one wait state per access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= apb_setup_done;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= apb_setup_done & ~addr_hit;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= probe_mux_pkg::WORD_ZERO;
		end else if (apb_setup_done && !pwrite) begin
			prdata <= read_word;
		end else begin
			prdata <= probe_mux_pkg::WORD_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	always_comb begin
		read_word = probe_mux_pkg::WORD_ZERO;
		addr_hit  = 1'b1;
		case (paddr)
			probe_mux_pkg::CTRL_OFFSET: begin
				read_word[probe_mux_pkg::CTRL_MODE_BIT] = mode;
				read_word[probe_mux_pkg::CTRL_SRC_LSB +: 2] = sample_src_sel;
			end
			probe_mux_pkg::BANK_SEL_OFFSET: begin
				read_word[7:0] = bank_sel;
			end
			probe_mux_pkg::STATUS_OFFSET: begin
				read_word[probe_mux_pkg::STATUS_BANK_LSB +: 8] = bank_sel;
				read_word[probe_mux_pkg::STATUS_DRIVE_BIT] = ~probe_oe_n[0];
				read_word[probe_mux_pkg::STATUS_MODE_BIT] = mode;
				read_word[probe_mux_pkg::STATUS_BANKS_LSB +: 8] = BANK_LIMIT;
				read_word[probe_mux_pkg::STATUS_PINS_LSB +: 8] = PIN_LIMIT;
			end
			probe_mux_pkg::SAMPLES_OFFSET: begin
				read_word = sample_count;
			end
			probe_mux_pkg::LANE_SEL_OFFSET: begin
				read_word[2:0] = lane_sel;
			end
			probe_mux_pkg::LANE_DATA_OFFSET: begin
				read_word = lane_word;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// pin readback, one 32-bit lane at a time
	always_comb begin
		int idx;
		idx = 0;
		lane_word = probe_mux_pkg::WORD_ZERO;
		for (int i = 0; i < 32; i++) begin
			idx = int'(lane_sel) * 32 + i;
			if (idx < PIN_COUNT) begin
				lane_word[i] = probe_view[idx];
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= MODE_RESET;
		end else if (wr_commit && paddr == probe_mux_pkg::CTRL_OFFSET) begin
			mode <= probe_mux_pkg::output_mode_type'(pwdata[probe_mux_pkg::CTRL_MODE_BIT]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_src_sel <= probe_mux_pkg::SRC_SEL_RESET;
		end else if (wr_commit && paddr == probe_mux_pkg::CTRL_OFFSET) begin
			sample_src_sel <= pwdata[probe_mux_pkg::CTRL_SRC_LSB +: 2];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_sel <= SEL_RESET;
		end else if (wr_commit && paddr == probe_mux_pkg::BANK_SEL_OFFSET) begin
			bank_sel <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_sel <= probe_mux_pkg::LANE_SEL_RESET;
		end else if (wr_commit && paddr == probe_mux_pkg::LANE_SEL_OFFSET) begin
			lane_sel <= (pwdata[2:0] > LANE_LAST) ? LANE_LAST : pwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// bank multiplexer
	// ----------------------------------------------------------------
	// out-of-range code means no bank
	assign bank_valid = bank_sel < BANK_LIMIT;

	generate
		for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
			// one signal per bank per pin
			always_comb begin
				bank_mux[p] = 1'b0;
				for (int b = 0; b < BANK_COUNT; b++) begin
					if (bank_valid && int'(bank_sel) == b) begin
						bank_mux[p] = bank_signals[b * PIN_COUNT + p];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// sample clock and registered path
	// ----------------------------------------------------------------
	assign sample_level = sample_sources[sample_src_sel];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_prev <= 1'b0;
		end else begin
			src_prev <= sample_level;
		end
	end

	// sample clock used only in state mode
	assign sample_edge = (mode == probe_mux_pkg::OUTPUT_STATE) & sample_level & ~src_prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			probe_state <= '0;
		end else if (sample_edge) begin
			probe_state <= bank_mux;
		end
	end

	// capture count; a clearing write in the same cycle as a capture leaves the count at 1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_count <= probe_mux_pkg::WORD_ZERO;
		end else if (wr_commit && paddr == probe_mux_pkg::SAMPLES_OFFSET) begin
			sample_count <= sample_edge ? probe_mux_pkg::COUNT_STEP : probe_mux_pkg::WORD_ZERO;
		end else if (sample_edge) begin
			sample_count <= sample_count + probe_mux_pkg::COUNT_STEP;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// timing mode bypasses probe_state; probe_oe_n is still registered
	always_comb begin
		if (mode == probe_mux_pkg::OUTPUT_STATE) begin
			probe_view = probe_state;
		end else begin
			probe_view = bank_mux;
		end
	end

	assign probe_out = probe_view;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			probe_oe_n <= {PIN_COUNT{~DRIVE_RESET}};
		end else begin
			probe_oe_n <= {PIN_COUNT{~bank_valid}};
		end
	end

endmodule

/* probe_mux_checker.sv */
// assertion checker for the banked probe multiplexer
`timescale 1ns/1ns
module probe_mux_checker #(
	parameter int PIN_COUNT  = 8,
	parameter int BANK_COUNT = 4
) (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	pready,
	input wire logic [31:0]	prdata,
	input wire logic	pslverr,
	input wire logic [BANK_COUNT*PIN_COUNT-1:0]	bank_signals,
	input wire logic [3:0]	sample_sources,
	input wire logic [PIN_COUNT-1:0]	probe_out,
	input wire logic [PIN_COUNT-1:0]	probe_oe_n
);
	logic [7:0]		sel_q;
	logic			mode_q;
	logic [1:0]		src_q;
	logic			wr;
	logic [PIN_COUNT-1:0]	cur;
	assign wr  = psel && penable && pready && pwrite && !pslverr;
	assign cur = bank_signals[sel_q*PIN_COUNT +: PIN_COUNT];
	// shadow of the host settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q  <= probe_mux_pkg::TRISTATE_CODE;
			mode_q <= 1'b0;
			src_q  <= 2'h0;
		end else if (wr && paddr == probe_mux_pkg::BANK_SEL_OFFSET) begin
			sel_q <= pwdata[7:0];
		end else if (wr && paddr == probe_mux_pkg::CTRL_OFFSET) begin
			{src_q, mode_q} <= {pwdata[9:8], pwdata[0]};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_access; psel && !penable ##1 psel && penable; endsequence
	sequence s_valid; sel_q < BANK_COUNT; endsequence
	sequence s_bad; sel_q >= BANK_COUNT; endsequence
	sequence s_edge; mode_q && sel_q < BANK_COUNT && $rose(sample_sources[src_q]); endsequence
	sequence s_quiet; mode_q && !wr && sel_q < BANK_COUNT && !$rose(sample_sources[src_q]); endsequence
	a_access_answer: assert property (s_access |=> pready)
		else $error("no answer on second access edge");
	a_pready_once: assert property (pready |=> !pready)
		else $error("pready stood too long");
	a_timing_pass: assert property (!mode_q && sel_q < BANK_COUNT |-> probe_out == cur)
		else $error("timing output differs from bank");
	a_tri_zero: assert property (!mode_q && sel_q >= BANK_COUNT |-> probe_out == '0)
		else $error("output not zero past last bank");
	a_sel_release: assert property (s_bad [*2] |-> probe_oe_n == '1)
		else $error("pins driven past last bank");
	a_sel_drive: assert property (s_valid [*2] |-> probe_oe_n == '0)
		else $error("pins not driven for valid bank");
	a_state_capture: assert property (s_edge |=> probe_out == $past(cur))
		else $error("sample edge did not capture bank");
	a_state_hold: assert property (s_quiet |=> $stable(probe_out))
		else $error("state output moved without sample edge");
endmodule
bind banked_signal_probe_mux probe_mux_checker #(.PIN_COUNT(PIN_COUNT), .BANK_COUNT(BANK_COUNT))
	chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.bank_signals(bank_signals), .sample_sources(sample_sources), .probe_out(probe_out),
	.probe_oe_n(probe_oe_n));

/* probe_analyzer.sv */
// external analyzer model sampling the probe pins
`timescale 1ns/1ns
module probe_analyzer #(
	parameter int PIN_COUNT = 8
) (
	input wire logic [PIN_COUNT-1:0]	probe_out,
	input wire logic [PIN_COUNT-1:0]	probe_oe_n,
	output logic [PIN_COUNT-1:0]		sample
);
	logic			la_clk = 1'b0;
	logic [PIN_COUNT-1:0]	pin;
	logic [PIN_COUNT-1:0]	last = '0;
	always #17 la_clk = ~la_clk;
	// released pins float, shown toggling
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			pin[i] = probe_oe_n[i] ? ~last[i] : probe_out[i];
		end
	end
	always @(posedge la_clk) begin
		sample <= pin;
		last   <= pin;
	end
endmodule

/* banked_signal_probe_mux_test.sv */
// self-checking bench for the banked probe multiplexer
`timescale 1ns/1ns
module banked_signal_probe_mux_test;
	localparam int PINS  = 8;
	localparam int BANKS = 4;
	logic		clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]	paddr, probe_out, probe_oe_n, seen;
	logic [31:0]	pwdata, prdata, bank_signals, r, v;
	logic [3:0]	sample_sources;
	int		errors, num_checks, cycles;
	banked_signal_probe_mux #(.PIN_COUNT(PINS), .BANK_COUNT(BANKS)) uut (.clk(clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.bank_signals(bank_signals), .sample_sources(sample_sources),
		.probe_out(probe_out), .probe_oe_n(probe_oe_n));
	probe_analyzer #(.PIN_COUNT(PINS)) la (.probe_out(probe_out), .probe_oe_n(probe_oe_n),
		.sample(seen));
	always #25 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [31:0] lane(input logic [31:0] bs, input int b);
		return b < BANKS ? {24'h000000, bs[b*PINS +: PINS]} : 32'h0;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
	endtask
	task automatic idle(input int n);
		psel    <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input int s);
		sample_sources <= 4'h0;
		repeat (2) @(posedge clk);
		sample_sources <= 4'h1 << s;
		repeat (3) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		{clk, rst_n, psel, penable, pwrite} = 5'h00;
		{paddr, pwdata, bank_signals, sample_sources} = 76'h0;
		void'($urandom(9));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({24'h000000, probe_oe_n}, 32'hFF);
		apb(1'b0, probe_mux_pkg::STATUS_OFFSET, 32'h0);
		chk(r, {8'(PINS), 8'(BANKS), 16'h00FF});
		apb(1'b0, 8'h20, 32'h0);
		chk({r[30:0], e}, 32'h1);
		for (int b = 0; b <= BANKS; b++) begin
			v = $urandom;
			bank_signals <= v;
			sample_sources <= 4'($urandom);
			apb(1'b1, probe_mux_pkg::BANK_SEL_OFFSET, 32'(b));
			apb(1'b0, probe_mux_pkg::BANK_SEL_OFFSET, 32'h0);
			chk(r, 32'(b));
			idle(3);
			chk({24'h000000, probe_out}, lane(v, b));
			chk({24'h000000, probe_oe_n}, b < BANKS ? 32'h0 : 32'hFF);
			if (b < BANKS)
				chk({24'h000000, seen}, lane(v, b));
		end
		apb(1'b0, probe_mux_pkg::SAMPLES_OFFSET, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h0);
		apb(1'b1, probe_mux_pkg::BANK_SEL_OFFSET, 32'h2);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, probe_mux_pkg::CTRL_OFFSET, {22'h0, 2'(s), 8'h01});
			idle(1);
			v = $urandom;
			bank_signals <= v;
			pulse(s);
			chk({24'h000000, probe_out}, lane(v, 2));
			bank_signals <= ~v;
			pulse((s + 1) % 4);
			chk({24'h000000, probe_out}, lane(v, 2));
		end
		apb(1'b0, probe_mux_pkg::STATUS_OFFSET, 32'h0);
		chk(r, {8'(PINS), 8'(BANKS), 16'h0302});
		apb(1'b1, probe_mux_pkg::LANE_SEL_OFFSET, 32'h7);
		apb(1'b0, probe_mux_pkg::LANE_SEL_OFFSET, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, probe_mux_pkg::LANE_DATA_OFFSET, 32'h0);
		chk(r, lane(v, 2));
		end_sim();
	end
endmodule
